/* File: hw/hsc_hyp_ctrl.sv */
`timescale 1ns/1ps
`include "hsc_cfg.svh"
// How it works
// R1: access in hyp, or monitor with world bit
// R2: bit 30 picks exception instruction set
// R3: exception entry loads endian flag from bit 25
// R4: bit 25 gives table walk byte order
// R5: low latency irq bit reads zero
// R6: bit 19 forces writable pages execute never
// R7: bit 12 enables instruction caches
// R8: bit 2 enables data caches
// R9: bit 1 enables alignment fault checks
// R10: bit 0 enables hypervisor stage 1 translation
// R11: software uses opcode1 4, c1, c0, 0
// R12: auxiliary register unimplemented, reads fixed, writes dropped
// R13: monitor mode always secure, else world bit
// R14: reserved bits hardwired, writes ignored
// R15: refused access becomes undefined, no change
module hsc_hyp_ctrl
  import hsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic req_i,
  input wire logic write_i,
  input wire logic [2:0] opc1_i,
  input wire logic [3:0] crn_i,
  input wire logic [3:0] crm_i,
  input wire logic [2:0] opc2_i,
  input wire logic [31:0] wdata_i,
  input wire logic [4:0] mode_i,
  input wire logic world_sel_i,
  input wire logic exc_entry_i,
  input wire logic walk_write_perm_i,
  output logic ack_o,
  output logic undef_o,
  output logic [31:0] rdata_o,
  output logic secure_o,
  output logic exception_compact_isa_o,
  output logic vector_byte_order_o,
  output logic status_endian_flag_o,
  output logic walk_big_endian_o,
  output logic walk_execute_never_o,
  output logic icache_en_o,
  output logic dcache_en_o,
  output logic align_check_o,
  output logic stage1_mmu_en_o
);
  // ==========================================
  // privilege gate
  hsc_gate_if gif ();

  assign gif.mode = mode_i;
  assign gif.world_sel = world_sel_i;

  hsc_access_gate u_gate (
    .g(gif)
  );

  // ==========================================
  // decode functions
  // true when the encoding fields name the wanted hyp register
  function automatic logic enc_hit(
    input logic [2:0] opc1,
    input logic [3:0] crn,
    input logic [3:0] crm,
    input logic [2:0] opc2,
    input logic [2:0] want
  );
    enc_hit = (opc1 == `HSC_OPC1_HYP) &&
              (crn == `HSC_CRN_C1) &&
              (crm == `HSC_CRM_C0) &&
              (opc2 == want); // see R11
  endfunction

  // only writable bits are stored; hardwired ones are merged on read
  function automatic logic [31:0] view(input logic [31:0] stored);
    view = (stored & `HSC_WR_MASK) | `HSC_RAO_MASK; // see R14 see R5
  endfunction

  // reserved bits are dropped on the way in, so they can never latch
  function automatic logic [31:0] keep_writable(input logic [31:0] data);
    keep_writable = data & `HSC_WR_MASK; // see R14
  endfunction

  // ==========================================
  // declarations
  hsc_state_t state_r;
  hsc_state_t state_nxt;
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic endian_r;
  logic endian_nxt;
  logic hit_ctrl;
  logic hit_aux;
  logic take;
  logic refuse;
  logic wr_ctrl;
  logic rd_ctrl;
  logic wr_aux;
  logic rd_aux;

  // ==========================================
  // request decode
  // wrong mode and unknown encoding are refused alike
  always_comb begin
    hit_ctrl = enc_hit(opc1_i, crn_i, crm_i, opc2_i, `HSC_OPC2_CTRL);
    hit_aux = enc_hit(opc1_i, crn_i, crm_i, opc2_i, `HSC_OPC2_AUX);
    take = req_i && (state_r == HSC_ST_IDLE);
    refuse = take && !((hit_ctrl || hit_aux) && gif.allowed); // see R1 see R15
    wr_ctrl = take && !refuse && hit_ctrl && write_i;
    rd_ctrl = take && !refuse && hit_ctrl && !write_i;
    // aux writes are answered but change nothing
    wr_aux = take && !refuse && hit_aux && write_i; // see R12
    rd_aux = take && !refuse && hit_aux && !write_i;
  end

  // ==========================================
  // access state
  // a request seen while answering is dropped, so software spaces them
  always_comb begin
    state_nxt = HSC_ST_IDLE;
    case (state_r)
      HSC_ST_IDLE: begin
        if (refuse) begin
          state_nxt = HSC_ST_UNDEF; // see R15
        end else if (wr_ctrl || rd_ctrl || wr_aux || rd_aux) begin
          state_nxt = HSC_ST_DONE;
        end else begin
          state_nxt = HSC_ST_IDLE;
        end
      end
      HSC_ST_DONE: begin
        state_nxt = HSC_ST_IDLE;
      end
      HSC_ST_UNDEF: begin
        state_nxt = HSC_ST_IDLE;
      end
      default: begin
        state_nxt = HSC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_r <= HSC_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================
  // control register
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = keep_writable(wdata_i); // see R14
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ctrl_r <= `HSC_RESET_VAL;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ==========================================
  // read data
  // holds the last read word until the next successful read
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_ctrl) begin
      rdata_nxt = view(ctrl_r); // see R14
    end else if (rd_aux) begin
      rdata_nxt = `HSC_AUX_READ; // see R12
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================
  // exception endian flag
  // an exception meeting a write in one cycle takes the old bit
  always_comb begin
    endian_nxt = endian_r;
    if (exc_entry_i) begin
      endian_nxt = ctrl_r[`HSC_BIT_ORDER]; // see R3
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      endian_r <= 1'h0;
    end else begin
      endian_r <= endian_nxt;
    end
  end

  // ==========================================
  // handshake outputs
  always_comb begin
    ack_o = (state_r == HSC_ST_DONE); // see R1
    undef_o = (state_r == HSC_ST_UNDEF); // see R15
  end

  // ==========================================
  // control outputs
  always_comb begin
    rdata_o = rdata_r;
    secure_o = gif.secure; // see R13
    exception_compact_isa_o = ctrl_r[`HSC_BIT_COMPACT]; // see R2
    vector_byte_order_o = ctrl_r[`HSC_BIT_ORDER];
    status_endian_flag_o = endian_r; // see R3
    walk_big_endian_o = ctrl_r[`HSC_BIT_ORDER]; // see R4
    walk_execute_never_o = ctrl_r[`HSC_BIT_WXN] && walk_write_perm_i; // see R6
    icache_en_o = ctrl_r[`HSC_BIT_ICACHE]; // see R7
    dcache_en_o = ctrl_r[`HSC_BIT_DCACHE]; // see R8
    align_check_o = ctrl_r[`HSC_BIT_ALIGN]; // see R9
    stage1_mmu_en_o = ctrl_r[`HSC_BIT_MMU]; // see R10
  end
endmodule // hsc_hyp_ctrl

/* File: hw/hsc_cfg.svh */
`ifndef HSC_CFG_SVH
`define HSC_CFG_SVH
// system coprocessor encodings of the two registers
`define HSC_OPC1_HYP 3'h4
`define HSC_CRN_C1 4'h1
`define HSC_CRM_C0 4'h0
`define HSC_OPC2_CTRL 3'h0
`define HSC_OPC2_AUX 3'h1
// field positions
`define HSC_BIT_COMPACT 30
`define HSC_BIT_ORDER 25
`define HSC_BIT_LLIRQ 21
`define HSC_BIT_WXN 19
`define HSC_BIT_ICACHE 12
`define HSC_BIT_DCACHE 2
`define HSC_BIT_ALIGN 1
`define HSC_BIT_MMU 0
// writable bits, hardwired ones, reset value of writable bits
`define HSC_WR_MASK 32'h4208_1007
`define HSC_RAO_MASK 32'h30c5_0878
`define HSC_RESET_VAL 32'h0000_0000
// value returned for the unimplemented auxiliary register
`define HSC_AUX_READ 32'h0000_0000
`endif

/* File: hw/hsc_pkg.sv */
package hsc_pkg;
  typedef enum logic [4:0] {
    HSC_MODE_USR = 5'h10,
    HSC_MODE_FIQ = 5'h11,
    HSC_MODE_IRQ = 5'h12,
    HSC_MODE_SVC = 5'h13,
    HSC_MODE_MON = 5'h16,
    HSC_MODE_ABT = 5'h17,
    HSC_MODE_HYP = 5'h1a,
    HSC_MODE_UND = 5'h1b,
    HSC_MODE_SYS = 5'h1f
  } hsc_mode_t;
  typedef enum logic [1:0] {
    HSC_ST_IDLE = 2'b00,
    HSC_ST_DONE = 2'b01,
    HSC_ST_UNDEF = 2'b10
  } hsc_state_t;
endpackage

/* File: hw/hsc_gate_if.sv */
`timescale 1ns/1ps
interface hsc_gate_if;
  logic [4:0] mode;
  logic world_sel;
  logic allowed;
  logic secure;
  modport gate (input mode, input world_sel, output allowed, output secure);
  modport user (output mode, output world_sel, input allowed, input secure);
endinterface

/* File: hw/hsc_access_gate.sv */
`timescale 1ns/1ps
module hsc_access_gate
  import hsc_pkg::*;
(
  hsc_gate_if.gate g
);
  // ==========================================
  // privilege and security decode
  always_comb begin
    g.allowed = (g.mode == HSC_MODE_HYP) || ((g.mode == HSC_MODE_MON) && g.world_sel); // see R1
    g.secure = (g.mode == HSC_MODE_MON) || !g.world_sel; // see R13
  end
endmodule // hsc_access_gate

/* File: tb/hsc_hyp_ctrl_checker.sv */
`timescale 1ns/1ps
// ==========
// port checker
module hsc_hyp_ctrl_checker (
  input logic clk_i,
  input logic resetn_i,
  input logic req_i,
  input logic write_i,
  input logic [2:0] opc2_i,
  input logic [4:0] mode_i,
  input logic world_sel_i,
  input logic exc_entry_i,
  input logic walk_write_perm_i,
  input logic ack_o,
  input logic undef_o,
  input logic [31:0] rdata_o,
  input logic secure_o,
  input logic vector_byte_order_o,
  input logic walk_big_endian_o,
  input logic status_endian_flag_o,
  input logic walk_execute_never_o,
  input logic icache_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire idle = !ack_o && !undef_o;
  wire ok = mode_i == 5'h1a || (mode_i == 5'h16 && world_sel_i);
  chk_one_answer: assert property (req_i && idle |=> ack_o ^ undef_o)
    else $error("no single answer");
  chk_mode_refused: assert property (req_i && idle && !ok |=> undef_o)
    else $error("bad mode taken");
  chk_secure_state: assert property (secure_o == (mode_i == 5'h16 || !world_sel_i))
    else $error("secure wrong");
  chk_noexec_perm: assert property (!walk_write_perm_i |-> !walk_execute_never_o)
    else $error("noexec without write");
  chk_walk_order: assert property (walk_big_endian_o == vector_byte_order_o)
    else $error("walk order differs");
  chk_endian_load: assert property (exc_entry_i |=> status_endian_flag_o == $past(vector_byte_order_o))
    else $error("endian flag not loaded");
  chk_fixed_bits: assert property (ack_o && !$past(write_i) && $past(opc2_i) == 3'h0 |->
    (rdata_o & 32'hbdf7_eff8) == 32'h30c5_0878)
    else $error("fixed bits wrong");
  chk_aux_zero: assert property (ack_o && !$past(write_i) && $past(opc2_i) == 3'h1 |-> rdata_o == 32'h0)
    else $error("aux read not zero");
  // reset may clear it, so only after a settled cycle
  chk_ctrl_hold: assert property ($past(resetn_i) && !ack_o |-> $stable(icache_en_o))
    else $error("control changed without access");
endmodule // hsc_hyp_ctrl_checker
bind hsc_hyp_ctrl hsc_hyp_ctrl_checker chk_i (
  .clk_i(clk_i),
  .resetn_i(resetn_i),
  .req_i(req_i),
  .write_i(write_i),
  .opc2_i(opc2_i),
  .mode_i(mode_i),
  .world_sel_i(world_sel_i),
  .exc_entry_i(exc_entry_i),
  .walk_write_perm_i(walk_write_perm_i),
  .ack_o(ack_o),
  .undef_o(undef_o),
  .rdata_o(rdata_o),
  .secure_o(secure_o),
  .vector_byte_order_o(vector_byte_order_o),
  .walk_big_endian_o(walk_big_endian_o),
  .status_endian_flag_o(status_endian_flag_o),
  .walk_execute_never_o(walk_execute_never_o),
  .icache_en_o(icache_en_o)
);

/* File: tb/hsc_hyp_ctrl_tb.sv */
`timescale 1ns/1ps
// ==========
// bench
module hsc_hyp_ctrl_tb import hsc_pkg::*; ;
  logic clk_i = 0, resetn_i = 0, req_i = 0, write_i = 0, world_sel_i = 0, exc_entry_i = 0, walk_write_perm_i = 0;
  logic [2:0] opc1_i = 3'h4, opc2_i = 3'h0;
  logic [3:0] crn_i = 4'h1, crm_i = 4'h0;
  logic [4:0] mode_i = 5'h1a;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic ack_o, undef_o, secure_o, exception_compact_isa_o, vector_byte_order_o, status_endian_flag_o;
  logic walk_big_endian_o, walk_execute_never_o, icache_en_o, dcache_en_o, align_check_o, stage1_mmu_en_o;
  wire [6:0] ctl = {exception_compact_isa_o, vector_byte_order_o, walk_big_endian_o, icache_en_o, dcache_en_o,
    align_check_o, stage1_mmu_en_o};
  int err_count = 0, total_checks = 0;
  always #5 clk_i = ~clk_i;
  hsc_hyp_ctrl dut (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .req_i(req_i),
    .write_i(write_i),
    .opc1_i(opc1_i),
    .crn_i(crn_i),
    .crm_i(crm_i),
    .opc2_i(opc2_i),
    .wdata_i(wdata_i),
    .mode_i(mode_i),
    .world_sel_i(world_sel_i),
    .exc_entry_i(exc_entry_i),
    .walk_write_perm_i(walk_write_perm_i),
    .ack_o(ack_o),
    .undef_o(undef_o),
    .rdata_o(rdata_o),
    .secure_o(secure_o),
    .exception_compact_isa_o(exception_compact_isa_o),
    .vector_byte_order_o(vector_byte_order_o),
    .status_endian_flag_o(status_endian_flag_o),
    .walk_big_endian_o(walk_big_endian_o),
    .walk_execute_never_o(walk_execute_never_o),
    .icache_en_o(icache_en_o),
    .dcache_en_o(dcache_en_o),
    .align_check_o(align_check_o),
    .stage1_mmu_en_o(stage1_mmu_en_o)
  );
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // req drops at the answer, which keeps two cycles between requests
  task automatic acc(input logic w, input logic [2:0] o, input logic [31:0] d, input logic [4:0] m, input logic s,
    input logic u, input logic [31:0] e);
    @(negedge clk_i);
    {req_i, write_i, opc2_i, wdata_i, mode_i, world_sel_i} <= {1'b1, w, o, d, m, s};
    @(negedge clk_i);
    req_i <= 1'b0;
    chk("ack", 32'(!u), 32'(ack_o));
    chk("undef", 32'(u), 32'(undef_o));
    if (!w && !u) chk("rdata", e, rdata_o);
  endtask
  task automatic pulse_exc(input logic e);
    @(negedge clk_i);
    exc_entry_i <= 1'b1;
    @(negedge clk_i);
    exc_entry_i <= 1'b0;
    @(negedge clk_i);
    chk("flag", 32'(e), 32'(status_endian_flag_o));
  endtask
  task t_write;
    acc(0, 0, 0, HSC_MODE_HYP, 0, 0, 32'h30c5_0878);
    acc(1, 0, '1, HSC_MODE_HYP, 0, 0, 0);
    chk("ctl", 7'h7f, ctl);
    acc(0, 0, 0, HSC_MODE_HYP, 0, 0, 32'h72cd_187f);
  endtask
  task t_refuse;
    acc(1, 0, 0, HSC_MODE_USR, 1, 1, 0);
    acc(1, 0, 0, HSC_MODE_MON, 0, 1, 0);
    acc(0, 0, 0, HSC_MODE_SVC, 1, 1, 0);
    acc(0, 0, 0, HSC_MODE_HYP, 0, 0, 32'h72cd_187f);
  endtask
  task t_mon;
    acc(1, 0, 32'h0200_0000, HSC_MODE_MON, 1, 0, 0);
    chk("secure", 1, 32'(secure_o));
    acc(0, 0, 0, HSC_MODE_MON, 1, 0, 32'h32c5_0878);
    chk("ctl", 7'h30, ctl);
    pulse_exc(1);
  endtask
  task t_aux;
    acc(1, 1, '1, HSC_MODE_HYP, 1, 0, 0);
    acc(0, 1, 0, HSC_MODE_HYP, 1, 0, 0);
    chk("secure", 0, 32'(secure_o));
    chk("ctl", 7'h30, ctl);
  endtask
  task t_wxn;
    acc(1, 0, 32'h0008_0000, HSC_MODE_HYP, 0, 0, 0);
    @(negedge clk_i);
    walk_write_perm_i <= 1'b1;
    @(negedge clk_i);
    chk("noexec", 1, 32'(walk_execute_never_o));
    walk_write_perm_i <= 1'b0;
    pulse_exc(0);
  endtask
  // single fields land on their own outputs, write permission alone forces nothing
  task t_fields;
    acc(1, 0, 32'h4000_1002, HSC_MODE_HYP, 0, 0, 0);
    chk("ctl", 7'h4a, ctl);
    walk_write_perm_i <= 1'h1;
    @(negedge clk_i);
    chk("noexec", 0, 32'(walk_execute_never_o));
    walk_write_perm_i <= 1'h0;
    acc(1, 0, 32'h0200_0005, HSC_MODE_HYP, 0, 0, 0);
    chk("ctl", 7'h35, ctl);
  endtask
  // every encoding field away from the register is refused
  task t_code;
    opc1_i <= 3'h0;
    acc(0, 0, 0, HSC_MODE_HYP, 0, 1, 0);
    {opc1_i, crn_i} <= {3'h4, 4'h2};
    acc(1, 0, '1, HSC_MODE_HYP, 0, 1, 0);
    {crn_i, crm_i} <= {4'h1, 4'h1};
    acc(1, 0, '1, HSC_MODE_HYP, 0, 1, 0);
    crm_i <= 4'h0;
    acc(0, 3'h2, 0, HSC_MODE_HYP, 0, 1, 0);
    acc(0, 0, 0, HSC_MODE_HYP, 0, 0, 32'h32c5_087d);
  endtask
  task finish_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk_i);
    resetn_i <= 1'b1;
    t_write;
    t_refuse;
    t_mon;
    t_aux;
    t_wxn;
    t_fields;
    t_code;
    finish_test;
  end
  // some twenty accesses fit well inside this
  initial begin
    #5000;
    err_count++;
    finish_test;
  end
endmodule // hsc_hyp_ctrl_tb
